//--- common/palette_pkg.sv
// package: register map, field layout and timing constants of the palette pixel path
package palette_pkg;
    // register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFS_MASK     = 8'h00;
    localparam logic [7:0] OFS_WADDR    = 8'h04;
    localparam logic [7:0] OFS_WDATA    = 8'h08;
    localparam logic [7:0] OFS_RADDR    = 8'h0c;
    localparam logic [7:0] OFS_RDATA    = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    // colour data word layout: red [23:16], green [15:8], blue [7:0]
    localparam int         RED_LSB      = 16;
    localparam int         GRN_LSB      = 8;
    localparam int         BLU_LSB      = 0;
    // reset values
    localparam logic [7:0] MASK_RST     = 8'hff;
    localparam logic [7:0] ADDR_RST     = 8'h00;
    // pipeline depth from sampled pixel to converter codes
    localparam int         PIPE_STAGES  = 3;
    // sync pedestal is 30 % of full scale, expressed in percent of a 10-bit code
    localparam int         SYNC_PCT     = 30;
    localparam int         CODE_W       = 10;
    localparam logic [CODE_W-1:0] SYNC_OFS = CODE_W'((SYNC_PCT * 1023) / 100);
    // FIFO of pending table writes
    localparam int         WFIFO_DEPTH  = 8;
    localparam int         WFIFO_WIDTH  = 32;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } rgb_t;

    typedef struct packed {
        logic [7:0] index;
        logic       blank_n;
        logic       sync_n;
    } pix_t;

    typedef struct packed {
        logic [7:0] addr;
        rgb_t       colour;
    } tbl_wr_t;
endpackage : palette_pkg

//--- verilog/sync_fifo.sv
// file: parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            case ({push, pop})
                2'b10:   count <= count + 1'b1;
                2'b01:   count <= count - 1'b1;
                default: count <= count;
            endcase
        end
    end
endmodule : sync_fifo
`default_nettype wire

//--- verilog/palette_pixel_path.sv
// file: palette pixel path with AHB-Lite register slave and colour table
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module palette_pixel_path
    import palette_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    // ahb-lite slave
    input  wire logic              hsel_i,
    input  wire logic [7:0]        haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [2:0]        hsize_i,
    input  wire logic [31:0]       hwdata_i,
    input  wire logic              hready_i,
    output logic      [31:0]       hrdata_o,
    output logic                   hreadyout_o,
    output logic                   hresp_o,
    // pixel pins from the display controller
    input  wire logic [7:0]        pixel_index_in_i,
    input  wire logic              blank_n_i,
    input  wire logic              sync_n_i,
    input  wire logic              mode_8bit_i,
    // converter codes
    output logic      [CODE_W-1:0] red_code_o,
    output logic      [CODE_W-1:0] green_code_o,
    output logic      [CODE_W-1:0] blue_code_o
);
    // pin synchronisers
    pix_t       pin_meta;
    pix_t       pin_sync;
    logic       mode_meta;
    logic       mode_sync;

    // pipeline stages
    pix_t       stage1;
    logic [7:0] stage2_addr;
    logic       stage2_blank_n;
    logic       stage2_sync_n;
    rgb_t       stage3_colour;
    logic       stage3_blank_n;
    logic       stage3_sync_n;

    // registers
    logic [7:0] pixel_mask;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;
    rgb_t       rd_data;
    rgb_t       colour_table [256];

    // ahb data phase
    logic       dp_valid;
    logic       dp_write;
    logic [7:0] dp_addr;
    logic       addr_phase;

    // table write fifo
    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [WFIFO_WIDTH-1:0] fifo_out_data;
    tbl_wr_t    fifo_entry;
    logic       fifo_overrun;

    function automatic logic [CODE_W-1:0] to_code(input logic [7:0] c,
                                                   input logic       m8,
                                                   input logic       bl_n,
                                                   input logic       sy_n);
        logic [7:0]        lvl;
        logic [CODE_W-1:0] full;
        lvl  = m8 ? c : {c[5:0], 2'b00};
        lvl  = bl_n ? lvl : 8'h00;
        // 8-bit white plus the pedestal lands exactly on full scale, keeping the pedestal at 30 %
        full = CODE_W'({lvl, 2'b00});
        full = CODE_W'((32'(full) * (1023 - SYNC_PCT * 1023 / 100)) / 1020);
        to_code = sy_n ? full + SYNC_OFS : full;
    endfunction : to_code

    // two flops on every pin before use
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_meta  <= '0;
            pin_sync  <= '0;
            mode_meta <= 1'b0;
            mode_sync <= 1'b0;
        end else begin
            pin_meta  <= '{index: pixel_index_in_i, blank_n: blank_n_i, sync_n: sync_n_i};
            pin_sync  <= pin_meta;
            mode_meta <= mode_8bit_i;
            mode_sync <= mode_meta;
        end
    end

    // pixel pipeline
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1         <= '0;
            stage2_addr    <= '0;
            stage2_blank_n <= 1'b0;
            stage2_sync_n  <= 1'b0;
            stage3_blank_n <= 1'b0;
            stage3_sync_n  <= 1'b0;
        end else begin
            stage1         <= pin_sync;
            stage2_addr    <= stage1.index & pixel_mask;
            stage2_blank_n <= stage1.blank_n;
            stage2_sync_n  <= stage1.sync_n;
            stage3_blank_n <= stage2_blank_n;
            stage3_sync_n  <= stage2_sync_n;
        end
    end

    // table read port for the pixel stream; table has no reset by design
    always_ff @(posedge clk_i) begin
        stage3_colour <= colour_table[stage2_addr];
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            red_code_o   <= '0;
            green_code_o <= '0;
            blue_code_o  <= '0;
        end else begin
            // same function on all three channels keeps composite levels matched
            red_code_o   <= to_code(stage3_colour.red, mode_sync,
                                    stage3_blank_n, stage3_sync_n);
            green_code_o <= to_code(stage3_colour.green, mode_sync,
                                    stage3_blank_n, stage3_sync_n);
            blue_code_o  <= to_code(stage3_colour.blue, mode_sync,
                                    stage3_blank_n, stage3_sync_n);
        end
    end

    // ahb-lite slave, zero wait states, always OKAY
    assign addr_phase  = hsel_i && hready_i && htrans_i[1];
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr  <= '0;
        end else begin
            dp_valid <= addr_phase;
            dp_write <= hwrite_i;
            dp_addr  <= haddr_i;
        end
    end

    // table writes queue in the fifo and drain one per cycle while pixels stream
    assign fifo_in_valid = dp_valid && dp_write && (dp_addr == OFS_WDATA);
    assign fifo_entry    = tbl_wr_t'(fifo_out_data);

    sync_fifo #(
        .WIDTH (WFIFO_WIDTH),
        .DEPTH (WFIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i       (clk_i),
        .arst_n_i    (arst_n_i),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   ({wr_addr, hwdata_i[23:0]}),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (1'b1),
        .out_data_o  (fifo_out_data)
    );

    always_ff @(posedge clk_i) begin
        if (fifo_out_valid) begin
            colour_table[fifo_entry.addr] <= fifo_entry.colour;
        end
    end

    // host registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pixel_mask   <= MASK_RST;
            wr_addr      <= ADDR_RST;
            rd_addr      <= ADDR_RST;
            fifo_overrun <= 1'b0;
        end else if (dp_valid && dp_write) begin
            case (dp_addr)
                OFS_MASK:  pixel_mask <= hwdata_i[7:0];
                OFS_WADDR: wr_addr    <= hwdata_i[7:0];
                OFS_RADDR: rd_addr    <= hwdata_i[7:0];
                OFS_WDATA: begin
                    wr_addr <= wr_addr + 8'h01;
                    if (!fifo_in_ready) begin
                        fifo_overrun <= 1'b1;
                    end
                end
                OFS_STATUS: begin
                    if (hwdata_i[1]) begin
                        fifo_overrun <= 1'b0;
                    end
                end
                default: ;
            endcase
        end else if (dp_valid && (dp_addr == OFS_RDATA)) begin
            rd_addr <= rd_addr + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        rd_data <= colour_table[rd_addr];
    end

    always_comb begin
        hrdata_o = 32'h0000_0000;
        if (dp_valid && !dp_write) begin
            case (dp_addr)
                OFS_MASK:   hrdata_o = {24'h000000, pixel_mask};
                OFS_WADDR:  hrdata_o = {24'h000000, wr_addr};
                OFS_RADDR:  hrdata_o = {24'h000000, rd_addr};
                OFS_RDATA:  hrdata_o = {8'h00, rd_data};
                OFS_STATUS: hrdata_o = {29'h0, mode_sync, fifo_overrun, fifo_out_valid};
                default:    hrdata_o = 32'h0000_0000;
            endcase
        end
    end
endmodule : palette_pixel_path
`default_nettype wire

//--- tb/palette_pixel_path_asserts.sv
// checker: pixel pipeline and bus response properties of the palette path
`timescale 1ns/1ps
`default_nettype none
module palette_pixel_path_asserts
    import palette_pkg::*;
(
    // watched ports
    input wire logic              clk_i,
    input wire logic              arst_n_i,
    input wire logic              hsel_i,
    input wire logic [7:0]        haddr_i,
    input wire logic [1:0]        htrans_i,
    input wire logic              hwrite_i,
    input wire logic              hready_i,
    input wire logic [31:0]       hrdata_o,
    input wire logic              hreadyout_o,
    input wire logic              hresp_o,
    input wire logic [7:0]        pixel_index_in_i,
    input wire logic              blank_n_i,
    input wire logic              sync_n_i,
    input wire logic              mode_8bit_i,
    input wire logic [CODE_W-1:0] red_code_o,
    input wire logic [CODE_W-1:0] green_code_o,
    input wire logic [CODE_W-1:0] blue_code_o
);
    logic [3:0] quiet;
    // colour span above the pedestal, and the brightest level a 6-bit colour can reach
    localparam logic [CODE_W-1:0] SPAN    = {CODE_W{1'b1}} - SYNC_OFS;
    localparam logic [CODE_W-1:0] SIX_TOP = CODE_W'((252 * int'(SPAN)) / 255);
    // bus traffic may retarget the table, so only bus-free stretches count
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            quiet <= 4'h0;
        else if (hsel_i || !$stable({pixel_index_in_i, blank_n_i, sync_n_i, mode_8bit_i}))
            quiet <= 4'h0;
        else if (quiet != 4'hf)
            quiet <= quiet + 4'h1;
    end
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // three held samples tolerate a one-edge slip in where the pipe starts
    blank_zero_a: assert property (
        (!blank_n_i && !sync_n_i) [*3] ##5 1'b1 |->
        {red_code_o, green_code_o, blue_code_o} == '0) else $error("blank not zero");
    blank_sync_a: assert property (
        (!blank_n_i && sync_n_i) [*3] ##5 1'b1 |-> red_code_o == SYNC_OFS &&
        green_code_o == SYNC_OFS && blue_code_o == SYNC_OFS) else $error("blank sync level");
    sync_low_a: assert property (
        (blank_n_i && !sync_n_i && mode_8bit_i) [*3] ##5 1'b1 |-> red_code_o <= SPAN &&
        green_code_o <= SPAN && blue_code_o <= SPAN) else $error("offset without sync");
    sync_high_a: assert property (
        (blank_n_i && sync_n_i) [*3] ##5 1'b1 |-> red_code_o >= SYNC_OFS &&
        green_code_o >= SYNC_OFS && blue_code_o >= SYNC_OFS) else $error("offset missing");
    mode_six_a: assert property (
        (blank_n_i && !sync_n_i && !mode_8bit_i) [*3] ##5 1'b1 |-> red_code_o <= SIX_TOP &&
        green_code_o <= SIX_TOP && blue_code_o <= SIX_TOP) else $error("wide code in 6-bit mode");
    codes_steady_a: assert property (
        quiet > 4'hb |-> $stable({red_code_o, green_code_o, blue_code_o}))
        else $error("codes moved with steady pins");
    bus_resp_a: assert property (
        hreadyout_o && !hresp_o) else $error("bus not ready or error");
    unmapped_rd_a: assert property (
        hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i == 8'h18 |=>
        hrdata_o == 32'h0) else $error("unmapped read not zero");
    cover property ((!blank_n_i) [*3]);
    cover property (blank_n_i && !mode_8bit_i);
    cover property (hsel_i && htrans_i[1] && hwrite_i && haddr_i == OFS_MASK);
endmodule : palette_pixel_path_asserts
`default_nettype wire

//--- tb/pixel_source_model.sv
// partner: display controller model that drives the pixel pins
`timescale 1ns/1ps
`default_nettype none
module pixel_source_model
    import palette_pkg::*;
(
    // clock and reset
    input wire logic  clk_i,
    input wire logic  arst_n_i,
    // pixel requested by the sequence
    input wire pix_t  want_i,
    input wire logic  want_8bit_i,
    // pins toward the palette
    output pix_t      pins_o,
    output logic      mode_8bit_o
);
    // pins move just after an edge, like a controller's output registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            pins_o <= '0;
        else
            pins_o <= want_i;
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
            mode_8bit_o <= 1'b1;
        else
            mode_8bit_o <= want_8bit_i;
    end
endmodule : pixel_source_model
`default_nettype wire

//--- tb/palette_pixel_path_bench.sv
// bench: bus tasks, pixel scenarios and verdict for the palette path
`timescale 1ns/1ps
`default_nettype none
module palette_pixel_path_bench
    import palette_pkg::*;
();
    logic              clk;
    logic              arst_n;
    logic              hsel;
    logic              hwrite;
    logic              hrdy;
    logic              hresp;
    logic [7:0]        haddr;
    logic [1:0]        htrans;
    logic [31:0]       hwdata;
    logic [31:0]       hrdata;
    logic [CODE_W-1:0] red;
    logic [CODE_W-1:0] grn;
    logic [CODE_W-1:0] blu;
    logic              m8;
    logic              want_8bit;
    pix_t              pins;
    pix_t              want;
    int                error_cnt = 0;
    int                samples_checked = 0;
    localparam rgb_t   col_z = 24'h112233;
    localparam rgb_t   col_a = 24'hc57efa;
    localparam rgb_t   col_b = 24'h4080ff;
    localparam rgb_t   col_t = 24'h010203;

    palette_pixel_path palette_pixel_path_inst (
        .clk_i(clk), .arst_n_i(arst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .pixel_index_in_i(pins.index), .blank_n_i(pins.blank_n), .sync_n_i(pins.sync_n),
        .mode_8bit_i(m8), .red_code_o(red), .green_code_o(grn), .blue_code_o(blu));
    pixel_source_model pixel_source_model_inst (
        .clk_i(clk), .arst_n_i(arst_n), .want_i(want), .want_8bit_i(want_8bit),
        .pins_o(pins), .mode_8bit_o(m8));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // one bus phase; values are taken settled just before the sampling edge
    task automatic phase(output logic [31:0] d);
        int   n;
        logic r;
        n = 0;
        do begin
            @(negedge clk);
            d = hrdata;
            r = hrdy;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 64);
        if (r !== 1'b1) begin
            error_cnt++;
            give_verdict();
        end
    endtask : phase

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        logic [31:0] junk;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        phase(junk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        phase(rd);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, a, wd, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        bus(1'b0, a, 32'h0, d);
        chk(what, d, exp);
    endtask : rdc

    function automatic logic [CODE_W-1:0] ex(input logic [7:0] c, input logic b,
                                             input logic s, input logic w8);
        int v;
        // colour span plus pedestal fills the code range; a 6-bit colour sits in the top six
        v = w8 ? int'(c) : 4 * int'(c[5:0]);
        v = b ? (v * (1023 - int'(SYNC_OFS))) / 255 : 0;
        return CODE_W'(v + (s ? int'(SYNC_OFS) : 0));
    endfunction : ex

    task automatic pix(input logic [7:0] i, input logic b, input logic s, input logic w8,
                       input rgb_t c, input string what);
        want <= {i, b, s};
        want_8bit <= w8;
        repeat (14) @(posedge clk);
        @(negedge clk);
        chk(what, {2'b00, red, grn, blu},
            {2'b00, ex(c.red, b, s, w8), ex(c.green, b, s, w8), ex(c.blue, b, s, w8)});
        @(posedge clk);
        $display("test %s done", what);
    endtask : pix

    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 8'h00;
        htrans = 2'b00;
        hwdata = 32'h0;
        // keep the pixels blanked until the table holds defined colours
        want = {8'h00, 1'b0, 1'b0};
        want_8bit = 1'b1;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rdc(OFS_MASK, {24'h0, MASK_RST}, "mask reset");
        rdc(8'h18, 32'h0, "unmapped read");
        wr(OFS_WADDR, 32'h00);
        wr(OFS_WDATA, {8'h00, col_z});
        wr(OFS_WDATA, {8'h00, col_a});
        wr(OFS_WADDR, 32'hf1);
        wr(OFS_WDATA, {8'h00, col_b});
        wr(OFS_WADDR, 32'hff);
        wr(OFS_WDATA, {8'h00, col_t});
        wr(OFS_RADDR, 32'hff);
        repeat (4) @(posedge clk);
        rdc(OFS_RDATA, {8'h00, col_t}, "top entry read");
        pix(8'hf1, 1'b1, 1'b1, 1'b1, col_b, "sync high");
        pix(8'h01, 1'b1, 1'b0, 1'b1, col_a, "sync low");
        pix(8'hf1, 1'b1, 1'b0, 1'b0, col_b, "six bit");
        pix(8'h01, 1'b1, 1'b1, 1'b0, col_a, "six bit sync");
        pix(8'h01, 1'b0, 1'b0, 1'b1, col_a, "blank");
        pix(8'h01, 1'b0, 1'b1, 1'b1, col_a, "blank sync");
        pix(8'hff, 1'b1, 1'b0, 1'b1, col_t, "entry 255");
        wr(OFS_MASK, 32'h0f);
        pix(8'hf1, 1'b1, 1'b0, 1'b1, col_a, "mask low nibble");
        wr(OFS_MASK, 32'h00);
        pix(8'hff, 1'b1, 1'b0, 1'b1, col_z, "mask zero");
        give_verdict();
    end
endmodule : palette_pixel_path_bench

bind palette_pixel_path palette_pixel_path_asserts palette_pixel_path_asserts_inst (
    .clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
    .hreadyout_o, .hresp_o, .pixel_index_in_i, .blank_n_i, .sync_n_i, .mode_8bit_i,
    .red_code_o, .green_code_o, .blue_code_o);
`default_nettype wire
